//--- src/adcmx_top.sv
// converter input mux, pairing and gain control registers
// assumes a synchronous byte-wide register bus and analog switches outside
// What this block does
// - converter powered only while enable bit set
// - all inputs single-ended after reset
// - gain taken from three-bit gain field
// - gain field resets to unity code
// - pair register upper nibble reads zero
// - bit 3 pairs even/odd port pins
// - bit 2 makes amplifier result signed
// - bit 1 pairs inputs 2 and 3
// - bit 0 pairs inputs 0 and 1
// - difference channels give two's complement data
// - any number of port pins enabled
// - even pins one input, odd another
// - amplifier output selectable like any channel
// - channel code low nibble, 8-15 temperature
// - eight pin enables reset to zero
`timescale 1ns/1ps
module adcmx_top #(
   parameter int PINS = 8
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WE,
   input wire logic SFR_RE,
   output logic [7:0] SFR_RDATA,
   output logic CONV_POWER_EN,
   output logic [2:0] GAIN_SEL,
   output adcmx_pkg::adcmx_src_t MUX_POS_SEL,
   output adcmx_pkg::adcmx_src_t MUX_NEG_SEL,
   output logic RESULT_TWOS_COMP,
   output logic [PINS-1:0] PIN_TO_EVEN,
   output logic [PINS-1:0] PIN_TO_ODD
);
   typedef struct packed {
      logic en;
      logic [2:0] gain;
      logic [3:0] pair;
      logic [3:0] chan;
      logic [PINS-1:0] pins;
      logic [7:0] rdata;
      adcmx_pkg::adcmx_src_t pos;
      adcmx_pkg::adcmx_src_t neg;
      logic diff;
   } adcmx_state_t;

   adcmx_state_t st_r;
   adcmx_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = adcmx_pkg::RDATA_IDLE;
      if (SFR_WE) begin
         unique case (SFR_ADDR)
            adcmx_pkg::ADDR_CONV_CTRL: begin
               st_nxt.en = SFR_WDATA[adcmx_pkg::ENABLE_BIT];
            end
            adcmx_pkg::ADDR_CONV_CFG: begin
               st_nxt.gain = SFR_WDATA[adcmx_pkg::GAIN_LSB +: 3];
            end
            adcmx_pkg::ADDR_PAIR_CFG: begin
               st_nxt.pair = SFR_WDATA[3:0];
            end
            adcmx_pkg::ADDR_CHAN_SEL: begin
               st_nxt.chan = SFR_WDATA[3:0];
            end
            adcmx_pkg::ADDR_PIN_SEL: begin
               st_nxt.pins = SFR_WDATA[PINS-1:0];
            end
            default: begin
            end
         endcase
      end
      // read data registered; unmapped addresses answer zero
      if (SFR_RE) begin
         unique case (SFR_ADDR)
            adcmx_pkg::ADDR_CONV_CTRL: begin
               st_nxt.rdata = 8'(st_r.en) << adcmx_pkg::ENABLE_BIT;
            end
            adcmx_pkg::ADDR_CONV_CFG: begin
               st_nxt.rdata = {5'h00, st_r.gain};
            end
            adcmx_pkg::ADDR_PAIR_CFG: begin
               st_nxt.rdata = {4'h0, st_r.pair};
            end
            adcmx_pkg::ADDR_CHAN_SEL: begin
               st_nxt.rdata = {4'h0, st_r.chan};
            end
            adcmx_pkg::ADDR_PIN_SEL: begin
               st_nxt.rdata = 8'(st_r.pins);
            end
            default: begin
               st_nxt.rdata = adcmx_pkg::RDATA_IDLE;
            end
         endcase
      end
      // decode from new settings, registered once
      st_nxt.pos = adcmx_pkg::SRC_AGND;
      st_nxt.neg = adcmx_pkg::SRC_AGND;
      st_nxt.diff = 1'b0;
      if (st_nxt.chan[adcmx_pkg::CHAN_TEMP_BIT]) begin
         // codes 8 to 15 pick temperature
         st_nxt.pos = adcmx_pkg::SRC_TEMP;
      end else begin
         unique case (st_nxt.chan[2:0])
            adcmx_pkg::CH_IN0, adcmx_pkg::CH_IN1: begin
               if (st_nxt.pair[adcmx_pkg::PAIR_IN01_BIT]) begin
                  st_nxt.pos = adcmx_pkg::SRC_IN0;
                  st_nxt.neg = adcmx_pkg::SRC_IN1;
                  st_nxt.diff = 1'b1;
               end else if (st_nxt.chan[0]) begin
                  st_nxt.pos = adcmx_pkg::SRC_IN1;
               end else begin
                  st_nxt.pos = adcmx_pkg::SRC_IN0;
               end
            end
            adcmx_pkg::CH_IN2, adcmx_pkg::CH_IN3: begin
               if (st_nxt.pair[adcmx_pkg::PAIR_IN23_BIT]) begin
                  st_nxt.pos = adcmx_pkg::SRC_IN2;
                  st_nxt.neg = adcmx_pkg::SRC_IN3;
                  st_nxt.diff = 1'b1;
               end else if (st_nxt.chan[0]) begin
                  st_nxt.pos = adcmx_pkg::SRC_IN3;
               end else begin
                  st_nxt.pos = adcmx_pkg::SRC_IN2;
               end
            end
            adcmx_pkg::CH_HV, adcmx_pkg::CH_GND: begin
               // signed mode measures against its reference
               if (st_nxt.pair[adcmx_pkg::PAIR_HV_BIT]) begin
                  st_nxt.pos = adcmx_pkg::SRC_HV_AMP;
                  st_nxt.neg = adcmx_pkg::SRC_HV_REF;
                  st_nxt.diff = 1'b1;
               end else if (st_nxt.chan[0]) begin
                  st_nxt.pos = adcmx_pkg::SRC_AGND;
               end else begin
                  st_nxt.pos = adcmx_pkg::SRC_HV_AMP;
               end
            end
            adcmx_pkg::CH_EVEN, adcmx_pkg::CH_ODD: begin
               if (st_nxt.pair[adcmx_pkg::PAIR_PINS_BIT]) begin
                  st_nxt.pos = adcmx_pkg::SRC_PIN_EVEN;
                  st_nxt.neg = adcmx_pkg::SRC_PIN_ODD;
                  st_nxt.diff = 1'b1;
               end else if (st_nxt.chan[0]) begin
                  st_nxt.pos = adcmx_pkg::SRC_PIN_ODD;
               end else begin
                  st_nxt.pos = adcmx_pkg::SRC_PIN_EVEN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         st_r <= '{en: adcmx_pkg::ENABLE_RESET,
                   gain: adcmx_pkg::GAIN_X1,
                   pair: adcmx_pkg::PAIR_RESET,
                   chan: adcmx_pkg::CHAN_RESET,
                   pins: adcmx_pkg::PINS_RESET[PINS-1:0],
                   rdata: adcmx_pkg::RDATA_IDLE,
                   pos: adcmx_pkg::SRC_IN0,
                   neg: adcmx_pkg::SRC_AGND,
                   diff: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign CONV_POWER_EN = st_r.en;
   assign GAIN_SEL = st_r.gain;
   assign MUX_POS_SEL = st_r.pos;
   assign MUX_NEG_SEL = st_r.neg;
   assign RESULT_TWOS_COMP = st_r.diff;
   assign SFR_RDATA = st_r.rdata;

   // pins join one even or one odd bus; shorts are the user's risk
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      if (i % 2 == 0) begin : g_even
         assign PIN_TO_EVEN[i] = st_r.pins[i];
         assign PIN_TO_ODD[i] = 1'b0;
      end else begin : g_odd
         assign PIN_TO_EVEN[i] = 1'b0;
         assign PIN_TO_ODD[i] = st_r.pins[i];
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   a_power_follows_enable: assert property (
      SFR_WE && SFR_ADDR == adcmx_pkg::ADDR_CONV_CTRL
      |=> CONV_POWER_EN == $past(SFR_WDATA[adcmx_pkg::ENABLE_BIT]))
      else $error("power enable not taken from write");
   a_reset_single_ended: assert property (
      $rose(RSTN) |-> !RESULT_TWOS_COMP
      && MUX_NEG_SEL == adcmx_pkg::SRC_AGND)
      else $error("pairing active after reset");
   a_gain_from_field: assert property (
      SFR_WE && SFR_ADDR == adcmx_pkg::ADDR_CONV_CFG
      |=> GAIN_SEL == $past(SFR_WDATA[2:0]))
      else $error("gain select not taken from field");
   a_gain_reset_unity: assert property (
      $rose(RSTN) |-> GAIN_SEL == adcmx_pkg::GAIN_X1)
      else $error("gain not unity after reset");
   a_pair_upper_zero: assert property (
      SFR_RE && SFR_ADDR == adcmx_pkg::ADDR_PAIR_CFG
      |=> SFR_RDATA[7:4] == 4'h0)
      else $error("pair register upper nibble not zero");
   a_pins_pair_mux: assert property (
      MUX_POS_SEL == adcmx_pkg::SRC_PIN_EVEN && RESULT_TWOS_COMP
      |-> MUX_NEG_SEL == adcmx_pkg::SRC_PIN_ODD)
      else $error("pin pair negative side wrong");
   a_hv_signed_ref: assert property (
      MUX_POS_SEL == adcmx_pkg::SRC_HV_AMP
      |-> RESULT_TWOS_COMP == (MUX_NEG_SEL == adcmx_pkg::SRC_HV_REF))
      else $error("amplifier signed mode mismatch");
   a_in23_pair: assert property (
      MUX_POS_SEL == adcmx_pkg::SRC_IN3 |-> !RESULT_TWOS_COMP)
      else $error("input 3 used alone while paired");
   a_in01_pair: assert property (
      MUX_NEG_SEL == adcmx_pkg::SRC_IN1 |-> MUX_POS_SEL
      == adcmx_pkg::SRC_IN0 && RESULT_TWOS_COMP)
      else $error("input 0/1 pair wrong");
   a_diff_signed: assert property (
      RESULT_TWOS_COMP == (MUX_NEG_SEL != adcmx_pkg::SRC_AGND))
      else $error("signed flag disagrees with pairing");
   a_temp_codes: assert property (
      SFR_WE && SFR_ADDR == adcmx_pkg::ADDR_CHAN_SEL && SFR_WDATA[3]
      |=> MUX_POS_SEL == adcmx_pkg::SRC_TEMP)
      else $error("codes 8-15 miss temperature sensor");
   a_pins_reset_zero: assert property (
      $rose(RSTN) |-> PIN_TO_EVEN == '0 && PIN_TO_ODD == '0)
      else $error("pin enables not cleared at reset");
   a_pair_next_cycle: assert property (
      SFR_WE && SFR_ADDR == adcmx_pkg::ADDR_PAIR_CFG && SFR_WDATA[0]
      && MUX_POS_SEL == adcmx_pkg::SRC_IN0
      |=> MUX_NEG_SEL == adcmx_pkg::SRC_IN1 && RESULT_TWOS_COMP)
      else $error("pairing change late");
   a_in01_takes_effect: assert property (
      SFR_WE && SFR_ADDR == adcmx_pkg::ADDR_CHAN_SEL
      && SFR_WDATA[3:0] == 4'h0
      |=> MUX_POS_SEL == adcmx_pkg::SRC_IN0
      && RESULT_TWOS_COMP == st_r.pair[adcmx_pkg::PAIR_IN01_BIT])
      else $error("channel change not effective next cycle");
   a_hv_any_channel: assert property (
      SFR_WE && SFR_ADDR == adcmx_pkg::ADDR_CHAN_SEL
      && SFR_WDATA[3:0] == {1'b0, adcmx_pkg::CH_HV}
      |=> MUX_POS_SEL == adcmx_pkg::SRC_HV_AMP)
      else $error("amplifier not selectable as channel");
   a_chan_upper_zero: assert property (
      SFR_RE && SFR_ADDR == adcmx_pkg::ADDR_CHAN_SEL
      |=> SFR_RDATA[7:4] == 4'h0)
      else $error("channel register upper nibble not zero");
   a_pins_any_number: assert property (
      SFR_WE && SFR_ADDR == adcmx_pkg::ADDR_PIN_SEL
      |=> (PIN_TO_EVEN | PIN_TO_ODD) == $past(SFR_WDATA[PINS-1:0]))
      else $error("pin enables not all taken");
   a_pins_side_split: assert property (
      SFR_WE && SFR_ADDR == adcmx_pkg::ADDR_PIN_SEL
      |=> PIN_TO_EVEN[0] == $past(SFR_WDATA[0]) && !PIN_TO_ODD[0]
      && PIN_TO_ODD[1] == $past(SFR_WDATA[1]) && !PIN_TO_EVEN[1])
      else $error("pin routed to wrong side");
   a_pins_reg_readback: assert property (
      SFR_RE && SFR_ADDR == adcmx_pkg::ADDR_PIN_SEL
      |=> SFR_RDATA[PINS-1:0] == ($past(PIN_TO_EVEN) | $past(PIN_TO_ODD)))
      else $error("pin register readback wrong");
   a_gain_held: assert property (
      !(SFR_WE && SFR_ADDR == adcmx_pkg::ADDR_CONV_CFG)
      |=> $stable(GAIN_SEL))
      else $error("gain changed without a write");
   a_power_held: assert property (
      !(SFR_WE && SFR_ADDR == adcmx_pkg::ADDR_CONV_CTRL)
      |=> $stable(CONV_POWER_EN))
      else $error("power changed without a write");
   a_mux_held: assert property (
      !SFR_WE |=> $stable(MUX_POS_SEL) && $stable(MUX_NEG_SEL))
      else $error("mux select changed without a write");

   c_temp_selected: cover property (MUX_POS_SEL == adcmx_pkg::SRC_TEMP);
   c_hv_signed: cover property (MUX_NEG_SEL == adcmx_pkg::SRC_HV_REF);
   c_pin_pair: cover property (MUX_NEG_SEL == adcmx_pkg::SRC_PIN_ODD);
   c_power_up: cover property ($rose(CONV_POWER_EN));
   c_in23_pair: cover property (MUX_NEG_SEL == adcmx_pkg::SRC_IN3);
endmodule // adcmx_top

//--- src/adcmx_pkg.sv
// package: register map, field layout, reset values and mux sources
// assumes a byte-wide special function register bus on the system clock
package adcmx_pkg;
   localparam logic [7:0] ADDR_PAIR_CFG = 8'hba;
   localparam logic [7:0] ADDR_CHAN_SEL = 8'hbb;
   localparam logic [7:0] ADDR_PIN_SEL = 8'hbd;
   localparam logic [7:0] ADDR_CONV_CTRL = 8'hc0;
   localparam logic [7:0] ADDR_CONV_CFG = 8'hc1;

   localparam int ENABLE_BIT = 7;
   localparam int GAIN_LSB = 0;
   localparam int PAIR_PINS_BIT = 3;
   localparam int PAIR_HV_BIT = 2;
   localparam int PAIR_IN23_BIT = 1;
   localparam int PAIR_IN01_BIT = 0;
   localparam int CHAN_TEMP_BIT = 3;

   localparam logic [3:0] PAIR_RESET = 4'h0;
   localparam logic [3:0] CHAN_RESET = 4'h0;
   localparam logic [7:0] PINS_RESET = 8'h00;
   localparam logic ENABLE_RESET = 1'b0;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // gain codes
   localparam logic [2:0] GAIN_X1 = 3'h0;
   localparam logic [2:0] GAIN_X2 = 3'h1;
   localparam logic [2:0] GAIN_X4 = 3'h2;
   localparam logic [2:0] GAIN_X8 = 3'h3;
   localparam logic [2:0] GAIN_X16 = 3'h4;
   localparam logic [2:0] GAIN_X0P5 = 3'h6;

   // channel codes of the low three bits
   localparam logic [2:0] CH_IN0 = 3'h0;
   localparam logic [2:0] CH_IN1 = 3'h1;
   localparam logic [2:0] CH_IN2 = 3'h2;
   localparam logic [2:0] CH_IN3 = 3'h3;
   localparam logic [2:0] CH_HV = 3'h4;
   localparam logic [2:0] CH_GND = 3'h5;
   localparam logic [2:0] CH_EVEN = 3'h6;
   localparam logic [2:0] CH_ODD = 3'h7;

   typedef enum logic [3:0] {
      SRC_AGND,
      SRC_IN0,
      SRC_IN1,
      SRC_IN2,
      SRC_IN3,
      SRC_HV_AMP,
      SRC_HV_REF,
      SRC_PIN_EVEN,
      SRC_PIN_ODD,
      SRC_TEMP
   } adcmx_src_t;
endpackage

//--- testbench/adc_input_mux_config_test.sv
// bench: drives the input mux control block through its register bus
// assumes the block alone on one 50 MHz clock with a synchronous low reset
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("unexpected %s exp %0h got %0h", nm, e, g); \
   end \
end
module adc_input_mux_config_test;
   logic clk;
   logic rstn;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic we;
   logic re;
   logic [7:0] rdata;
   logic pwr;
   logic [2:0] gain;
   adcmx_pkg::adcmx_src_t pos;
   adcmx_pkg::adcmx_src_t neg;
   logic twos;
   logic [7:0] p_even;
   logic [7:0] p_odd;
   int num_errors;
   int n_compared;

   adcmx_top dut_u (.CLK(clk), .RSTN(rstn), .SFR_ADDR(addr),
      .SFR_WDATA(wdata), .SFR_WE(we), .SFR_RE(re), .SFR_RDATA(rdata),
      .CONV_POWER_EN(pwr), .GAIN_SEL(gain), .MUX_POS_SEL(pos),
      .MUX_NEG_SEL(neg), .RESULT_TWOS_COMP(twos), .PIN_TO_EVEN(p_even),
      .PIN_TO_ODD(p_odd));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic stop_test;
      if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // checks run one ns after the edge that took the access
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic t_reset;
      logic [7:0] d;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      #1;
      `CHK("power", 1'b0, pwr)
      `CHK("gain", adcmx_pkg::GAIN_X1, gain)
      `CHK("pos", adcmx_pkg::SRC_IN0, pos)
      `CHK("neg", adcmx_pkg::SRC_AGND, neg)
      `CHK("signed", 1'b0, twos)
      `CHK("even pins", 8'h00, p_even)
      `CHK("odd pins", 8'h00, p_odd)
      rd(adcmx_pkg::ADDR_PAIR_CFG, d);
      `CHK("pair reg", 8'h00, d)
      rd(adcmx_pkg::ADDR_PIN_SEL, d);
      `CHK("pin reg", 8'h00, d)
   endtask

   // reserved upper nibbles and an unmapped address
   task automatic t_regs;
      logic [7:0] d;
      wr(adcmx_pkg::ADDR_PAIR_CFG, 8'hff);
      rd(adcmx_pkg::ADDR_PAIR_CFG, d);
      `CHK("pair reg", 8'h0f, d)
      @(posedge clk);
      #1;
      `CHK("idle rdata", 8'h00, rdata)
      wr(adcmx_pkg::ADDR_CHAN_SEL, 8'hf9);
      rd(adcmx_pkg::ADDR_CHAN_SEL, d);
      `CHK("chan reg", 8'h09, d)
      `CHK("temp pos", adcmx_pkg::SRC_TEMP, pos)
      wr(8'hbc, 8'hff);
      rd(8'hbc, d);
      `CHK("unmapped", 8'h00, d)
   endtask

   task automatic t_power;
      logic [7:0] d;
      wr(adcmx_pkg::ADDR_CONV_CTRL, 8'h80);
      `CHK("power on", 1'b1, pwr)
      rd(adcmx_pkg::ADDR_CONV_CTRL, d);
      `CHK("ctrl reg", 8'h80, d)
      wr(adcmx_pkg::ADDR_CONV_CTRL, 8'h00);
      `CHK("power off", 1'b0, pwr)
      wr(adcmx_pkg::ADDR_CONV_CTRL, 8'h80);
      `CHK("power on again", 1'b1, pwr)
   endtask

   task automatic t_gain;
      logic [2:0] gl [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
      logic [7:0] d;
      for (int i = 0; i < 6; i++) begin
         wr(adcmx_pkg::ADDR_CONV_CFG, {5'h00, gl[i]});
         `CHK("gain", gl[i], gain)
      end
      rd(adcmx_pkg::ADDR_CONV_CFG, d);
      `CHK("gain reg", 8'h06, d)
   endtask

   // even and odd pins split onto their own buses, several at once
   task automatic t_pins;
      wr(adcmx_pkg::ADDR_PIN_SEL, 8'ha5);
      `CHK("even", 8'h05, p_even)
      `CHK("odd", 8'ha0, p_odd)
      wr(adcmx_pkg::ADDR_PIN_SEL, 8'hff);
      `CHK("all even", 8'h55, p_even)
      `CHK("all odd", 8'haa, p_odd)
   endtask

   // every channel code against every pairing, checked the next cycle
   task automatic t_mux;
      adcmx_pkg::adcmx_src_t e;
      adcmx_pkg::adcmx_src_t o;
      adcmx_pkg::adcmx_src_t ep;
      adcmx_pkg::adcmx_src_t en;
      logic [3:0] ch;
      logic [3:0] cf;
      logic s;
      for (int c = 0; c < 16; c++) begin
         ch = c[3:0];
         wr(adcmx_pkg::ADDR_CHAN_SEL, {4'h0, ch});
         for (int f = 0; f < 16; f++) begin
            cf = f[3:0];
            case (ch[2:1])
               2'h0: begin
                  e = adcmx_pkg::SRC_IN0;
                  o = adcmx_pkg::SRC_IN1;
               end
               2'h1: begin
                  e = adcmx_pkg::SRC_IN2;
                  o = adcmx_pkg::SRC_IN3;
               end
               2'h2: begin
                  e = adcmx_pkg::SRC_HV_AMP;
                  o = adcmx_pkg::SRC_AGND;
               end
               default: begin
                  e = adcmx_pkg::SRC_PIN_EVEN;
                  o = adcmx_pkg::SRC_PIN_ODD;
               end
            endcase
            s = cf[ch[2:1]] & ~ch[3];
            ep = (s || !ch[0]) ? e : o;
            en = s ? o : adcmx_pkg::SRC_AGND;
            if (s && ch[2:1] == 2'h2) en = adcmx_pkg::SRC_HV_REF;
            if (ch[3]) ep = adcmx_pkg::SRC_TEMP;
            wr(adcmx_pkg::ADDR_PAIR_CFG, {4'h0, cf});
            `CHK("pos", ep, pos)
            `CHK("neg", en, neg)
            `CHK("signed", s, twos)
         end
      end
   endtask

   initial begin
      rstn = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      we = 1'b0;
      re = 1'b0;
      num_errors = 0;
      n_compared = 0;
      t_reset();
      t_regs();
      t_power();
      t_gain();
      t_pins();
      t_mux();
      // mid-run reset with every setting away from its default
      t_reset();
      stop_test();
   end

   // bounded run; a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("unexpected run length exp done got timeout");
      stop_test();
   end
endmodule // adc_input_mux_config_test
